// File: hw/ubsc_consts.vh
/*
 * Constants for the USB device bus-state control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz pclk and an APB register bus with 32-bit data.
 */
`ifndef UBSC_CONSTS_VH
`define UBSC_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define UBSC_OFF_ENABLE      12'h000
`define UBSC_OFF_PULLUP      12'h004
`define UBSC_OFF_LINEVAL     12'h008
`define UBSC_OFF_TASKS       12'h00c
`define UBSC_OFF_CAUSE       12'h010
`define UBSC_OFF_ADDR        12'h014
`define UBSC_OFF_EPEN        12'h018
`define UBSC_OFF_STATUS      12'h01c
`define UBSC_OFF_WAKEEN      12'h020

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UBSC_TASK_DRIVE      0
`define UBSC_TASK_RELEASE    1
`define UBSC_CAUSE_READY     0
`define UBSC_CAUSE_SUSPEND   1
`define UBSC_CAUSE_RESUME    2
`define UBSC_CAUSE_RESET     3

// Line state codes, D+ in bit 1 and D- in bit 0.
`define UBSC_LS_SE0          2'h0
`define UBSC_LS_K            2'h1
`define UBSC_LS_J            2'h2
`define UBSC_LS_SE1          2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UBSC_RST_ENABLE      1'h0
`define UBSC_RST_PULLUP      1'h0
`define UBSC_RST_ADDR        7'h00
`define UBSC_RST_EPEN        16'h0001

// ----------------------------------------------------------------------
// Timing: times in ns, cycle counts derived from the 10 ns period
// ----------------------------------------------------------------------
`define UBSC_CLK_PERIOD_NS   10
`define UBSC_DETRST_NS       2500
`define UBSC_DETRST_CYC      ((`UBSC_DETRST_NS + `UBSC_CLK_PERIOD_NS - 1) / `UBSC_CLK_PERIOD_NS)
`define UBSC_SUSPEND_NS      3000000
`define UBSC_SUSPEND_CYC     ((`UBSC_SUSPEND_NS + `UBSC_CLK_PERIOD_NS - 1) / `UBSC_CLK_PERIOD_NS)
`define UBSC_PWRUP_NS        1000
`define UBSC_PWRUP_CYC       ((`UBSC_PWRUP_NS + `UBSC_CLK_PERIOD_NS - 1) / `UBSC_CLK_PERIOD_NS)
`define UBSC_PWRDN_NS        1000
`define UBSC_PWRDN_CYC       ((`UBSC_PWRDN_NS + `UBSC_CLK_PERIOD_NS - 1) / `UBSC_CLK_PERIOD_NS)

`endif

// File: hw/ubsc_bus_state_ctrl.v
/*
 * USB device bus-state and connection control: transceiver enable, D+
 * pull-up, J/K/SE0/SE1 decoding, bus reset, suspend and resume detection
 * and forced line driving, with an APB register slave.
 * Assumes dp_i/dm_i are already synchronous to pclk and that vbus_valid
 * reports the supply comparator level.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ubsc_consts.vh"

// What this block does
// - Decode J and K line states
// - Decode SE0 and SE1 line states
// - Idle means bus held in J
// - Drivers, pull-up need VBUS and enable
// - Transceiver power follows enable register
// - Enable reads enabled until fully disabled
// - Traffic and events other than power-ready only with pull-up
// - Pull-up disconnected after chip reset
// - No bus reset while pull-up off
// - Pull-up strength follows bus activity automatically
// - Force task drives lines, release frees
// - Long SE0 raises bus-reset event only
// - Bus reset clears address, endpoints back to endpoint 0 only
// - Ignore traffic until first bus reset
// - Full speed only, ignore chirp
// - Detect idle and enter suspend
// - Resume on any non-idle signalling
// - Remote wake-up only when enabled
// - Idle timeout raises suspend cause event
// - Non-J state raises resume cause event
module ubsc_bus_state_ctrl
#(
    parameter SUSPEND_CYC = `UBSC_SUSPEND_CYC
)
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        vbus_valid,
    input  wire        phy_power_ok,
    input  wire        dp_i,
    input  wire        dm_i,
    output reg         dp_o,
    output reg         dp_oe,
    output reg         dm_o,
    output reg         dm_oe,
    output reg         pullup_on,
    output reg         pullup_strong,
    output reg         phy_power_on,
    output reg         traffic_allow,
    output reg         suspended,
    output reg         bus_reset_event,
    output reg         general_bus_event,
    output reg         phy_power_ready_event
);

    // Power sequencer states.
    localparam [1:0] PWR_OFF  = 2'h0;
    localparam [1:0] PWR_UP   = 2'h1;
    localparam [1:0] PWR_ON   = 2'h2;
    localparam [1:0] PWR_DOWN = 2'h3;

    // Integer counts cut to counter width.
    localparam integer PWRUP_INT  = `UBSC_PWRUP_CYC;
    localparam integer PWRDN_INT  = `UBSC_PWRDN_CYC;
    localparam integer DETRST_INT = `UBSC_DETRST_CYC;

    localparam [15:0] PWRUP_CYC  = PWRUP_INT[15:0];
    localparam [15:0] PWRDN_CYC  = PWRDN_INT[15:0];
    localparam [15:0] DETRST_CYC = DETRST_INT[15:0];
    localparam [31:0] SUSP_CYC   = SUSPEND_CYC;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg        enable_q;
    reg [1:0]  pwr_state_q;
    reg [15:0] pwr_cnt_q;
    reg        pullup_q;
    reg        wake_en_q;
    reg [1:0]  line_val_q;
    reg        forcing_q;
    reg [1:0]  forced_line_state_q;
    reg [3:0]  event_cause_q;
    reg [6:0]  device_address_q;
    reg [15:0] ep_enable_q;
    reg [15:0] se0_cnt_q;
    reg        reset_seen_q;
    reg [31:0] idle_cnt_q;
    reg        susp_q;

    wire [1:0] line_state = {dp_i, dm_i};
    wire       ls_j   = (line_state == `UBSC_LS_J);
    wire       ls_k   = (line_state == `UBSC_LS_K);
    wire       ls_se0 = (line_state == `UBSC_LS_SE0);
    wire       ls_se1 = (line_state == `UBSC_LS_SE1);
    wire       bus_idle = ls_j;
    wire       phy_live = vbus_valid && (pwr_state_q == PWR_ON);
    wire       connected = phy_live && pullup_q;

    // Write at access edge, read at setup.
    wire       wr_en = psel && penable && pwrite && pready;
    wire       rd_en = psel && !penable && !pwrite;

    // Cause bits written with one are cleared; a same-cycle set wins.
    wire       wr_cause = wr_en && (paddr == `UBSC_OFF_CAUSE);
    wire       wr_task  = wr_en && (paddr == `UBSC_OFF_TASKS);

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    wire rst_hit  = connected && ls_se0 &&
                    (se0_cnt_q == DETRST_CYC - 16'h0001);
    wire susp_hit = connected && !susp_q && bus_idle &&
                    (idle_cnt_q == SUSP_CYC - 32'h00000001);
    wire res_hit  = connected && susp_q && !bus_idle;
    wire rdy_hit  = (pwr_state_q == PWR_UP) &&
                    (pwr_cnt_q == 16'h0000) && phy_power_ok;

    // ------------------------------------------------------------------
    // Power sequencer: PHY power tracks the enable register.
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_state_q <= PWR_OFF;
            pwr_cnt_q   <= 16'h0000;
        end
        else
        begin
            case (pwr_state_q)
                PWR_OFF:
                    if (enable_q)
                    begin
                        pwr_state_q <= PWR_UP;
                        pwr_cnt_q   <= PWRUP_CYC;
                    end
                PWR_UP:
                    if (!enable_q)
                    begin
                        pwr_state_q <= PWR_DOWN;
                        pwr_cnt_q   <= PWRDN_CYC;
                    end
                    else if (pwr_cnt_q != 16'h0000)
                        pwr_cnt_q <= pwr_cnt_q - 16'h0001;
                    else if (phy_power_ok)
                        pwr_state_q <= PWR_ON;
                PWR_ON:
                    if (!enable_q)
                    begin
                        pwr_state_q <= PWR_DOWN;
                        pwr_cnt_q   <= PWRDN_CYC;
                    end
                default:
                    if (pwr_cnt_q != 16'h0000)
                        pwr_cnt_q <= pwr_cnt_q - 16'h0001;
                    else
                        pwr_state_q <= PWR_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Line watchers: SE0 length, idle length, suspend and first reset.
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            se0_cnt_q    <= 16'h0000;
            idle_cnt_q   <= 32'h00000000;
            susp_q       <= 1'b0;
            reset_seen_q <= 1'b0;
        end
        else if (!connected)
        begin
            // Without the pull-up the host pull-downs give SE0; ignore it.
            se0_cnt_q    <= 16'h0000;
            idle_cnt_q   <= 32'h00000000;
            susp_q       <= 1'b0;
            reset_seen_q <= 1'b0;
        end
        else
        begin
            // Counters saturate: hits fire once.
            if (!ls_se0)
                se0_cnt_q <= 16'h0000;
            else if (se0_cnt_q != DETRST_CYC)
                se0_cnt_q <= se0_cnt_q + 16'h0001;
            if (!bus_idle)
                idle_cnt_q <= 32'h00000000;
            else if (idle_cnt_q != SUSP_CYC)
                idle_cnt_q <= idle_cnt_q + 32'h00000001;
            if (susp_hit)
                susp_q <= 1'b1;
            else if (res_hit)
                susp_q <= 1'b0;
            if (rst_hit)
                reset_seen_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Event pulses and status outputs.
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_reset_event       <= 1'b0;
            general_bus_event     <= 1'b0;
            phy_power_ready_event <= 1'b0;
            suspended             <= 1'b0;
            traffic_allow         <= 1'b0;
            pullup_on             <= 1'b0;
            pullup_strong         <= 1'b0;
            phy_power_on          <= 1'b0;
        end
        else
        begin
            bus_reset_event       <= rst_hit;
            general_bus_event     <= susp_hit || res_hit || rdy_hit;
            phy_power_ready_event <= rdy_hit;
            suspended             <= susp_hit || (susp_q && !res_hit);
            // Full-speed only: no chirp answer, traffic after first reset.
            traffic_allow         <= connected && reset_seen_q;
            pullup_on             <= connected;
            // Stronger pull-up while the bus is active, weaker when idle.
            pullup_strong         <= connected && !bus_idle;
            phy_power_on          <= enable_q;
        end
    end

    // ------------------------------------------------------------------
    // Forced line drive; J, K, SE1 or a released bus, never SE0.
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            forcing_q           <= 1'b0;
            forced_line_state_q <= `UBSC_LS_J;
            dp_o                <= 1'b0;
            dm_o                <= 1'b0;
            dp_oe               <= 1'b0;
            dm_oe               <= 1'b0;
        end
        else
        begin
            if (!phy_live || (wr_task && pwdata[`UBSC_TASK_RELEASE]))
                forcing_q <= 1'b0;
            else if (wr_task && pwdata[`UBSC_TASK_DRIVE] &&
                     (line_val_q != `UBSC_LS_SE0 || wake_en_q))
            begin
                // The value is captured only when the task fires.
                forcing_q           <= 1'b1;
                // Resume request sends K, never SE0.
                if (line_val_q == `UBSC_LS_SE0)
                    forced_line_state_q <= `UBSC_LS_K;
                else
                    forced_line_state_q <= line_val_q;
            end
            dp_o  <= forced_line_state_q[1];
            dm_o  <= forced_line_state_q[0];
            dp_oe <= forcing_q && phy_live;
            dm_oe <= forcing_q && phy_live;
        end
    end

    // ------------------------------------------------------------------
    // APB register slave: zero wait states, error on unmapped address.
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q         <= `UBSC_RST_ENABLE;
            pullup_q         <= `UBSC_RST_PULLUP;
            wake_en_q        <= 1'b0;
            line_val_q       <= `UBSC_LS_J;
            event_cause_q    <= 4'h0;
            device_address_q <= `UBSC_RST_ADDR;
            ep_enable_q      <= `UBSC_RST_EPEN;
            prdata           <= 32'h00000000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
        end
        else
        begin
            // Answer every access at once.
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                if (paddr != `UBSC_OFF_ENABLE && paddr != `UBSC_OFF_PULLUP &&
                    paddr != `UBSC_OFF_LINEVAL && paddr != `UBSC_OFF_TASKS &&
                    paddr != `UBSC_OFF_CAUSE && paddr != `UBSC_OFF_ADDR &&
                    paddr != `UBSC_OFF_EPEN && paddr != `UBSC_OFF_STATUS &&
                    paddr != `UBSC_OFF_WAKEEN)
                    pslverr <= 1'b1;
            end
            // Read data stands in the access cycle.
            if (rd_en)
            begin
                if (paddr == `UBSC_OFF_ENABLE)
                    prdata <= {31'h0, enable_q || (pwr_state_q != PWR_OFF)};
                else if (paddr == `UBSC_OFF_PULLUP)
                    prdata <= {31'h0, pullup_q};
                else if (paddr == `UBSC_OFF_LINEVAL)
                    prdata <= {30'h0, line_val_q};
                else if (paddr == `UBSC_OFF_CAUSE)
                    prdata <= {28'h0, event_cause_q};
                else if (paddr == `UBSC_OFF_ADDR)
                    prdata <= {25'h0, device_address_q};
                else if (paddr == `UBSC_OFF_EPEN)
                    prdata <= {16'h0, ep_enable_q};
                else if (paddr == `UBSC_OFF_STATUS)
                    prdata <= {26'h0, reset_seen_q, susp_q, ls_se1,
                               ls_se0, ls_k, ls_j};
                else if (paddr == `UBSC_OFF_WAKEEN)
                    prdata <= {31'h0, wake_en_q};
                else
                    prdata <= 32'h00000000;
            end
            if (wr_en && paddr == `UBSC_OFF_ENABLE)
                enable_q <= pwdata[0];
            if (wr_en && paddr == `UBSC_OFF_PULLUP)
                pullup_q <= pwdata[0];
            if (wr_en && paddr == `UBSC_OFF_LINEVAL)
                line_val_q <= pwdata[1:0];
            if (wr_en && paddr == `UBSC_OFF_WAKEEN)
                wake_en_q <= pwdata[0];
            // Bus reset wins over a software write to address and endpoints.
            if (rst_hit)
            begin
                device_address_q <= `UBSC_RST_ADDR;
                ep_enable_q      <= `UBSC_RST_EPEN;
            end
            else
            begin
                if (wr_en && paddr == `UBSC_OFF_ADDR)
                    device_address_q <= pwdata[6:0];
                if (wr_en && paddr == `UBSC_OFF_EPEN)
                    ep_enable_q <= pwdata[15:0];
            end
            // Write one to clear; a hardware set in the same cycle wins.
            event_cause_q <= (event_cause_q &
                              ~(wr_cause ? pwdata[3:0] : 4'h0)) |
                             {rst_hit, res_hit, susp_hit, rdy_hit};
        end
    end

endmodule
`default_nettype wire

// File: verification/ubsc_checker.sv
/* Port assertions and covers for the USB bus-state control block.
   Assumes one 100 MHz pclk domain and presetn asynchronous, active low. */
`timescale 1ns/1ps
`default_nettype none
module ubsc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic vbus_valid,
    input wire logic phy_power_ok,
    input wire logic dp_i,
    input wire logic dm_i,
    input wire logic dp_oe,
    input wire logic dm_oe,
    input wire logic pullup_on,
    input wire logic pullup_strong,
    input wire logic phy_power_on,
    input wire logic traffic_allow,
    input wire logic suspended,
    input wire logic bus_reset_event,
    input wire logic general_bus_event,
    input wire logic phy_power_ready_event
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------------------
    // Helper logic
    // --------------------
    logic [15:0] se0_cnt_q;
    // Counts consecutive SE0 samples while the pull-up is connected.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            se0_cnt_q <= 16'h0000;
        else if (pullup_on && !dp_i && !dm_i)
            se0_cnt_q <= se0_cnt_q + 16'h0001;
        else
            se0_cnt_q <= 16'h0000;
    // --------------------
    // Assertions
    // --------------------
    a_vbus_gate: assert property (!vbus_valid |=> !pullup_on)
        else $error("pull-up stays on without vbus");
    a_ready_power: assert property (phy_power_ready_event |-> phy_power_on && $past(phy_power_ok))
        else $error("ready event without phy power");
    a_strong_gate: assert property (!pullup_on [*2] |-> !pullup_strong)
        else $error("strong pull-up while disconnected");
    a_traffic_gate: assert property (!pullup_on [*2] |-> !traffic_allow)
        else $error("traffic allowed while disconnected");
    a_traffic_first: assert property ($rose(traffic_allow) |-> bus_reset_event || $past(bus_reset_event))
        else $error("traffic allowed before a bus reset");
    a_reset_conn: assert property (bus_reset_event |-> $past(pullup_on))
        else $error("bus reset while pull-up off");
    a_reset_se0: assert property (bus_reset_event |-> $past(se0_cnt_q) >= 16'd240)
        else $error("bus reset after short SE0");
    a_reset_bound: assert property (se0_cnt_q == 16'd245 |-> ##[1:12] bus_reset_event)
        else $error("long SE0 gave no bus reset");
    a_reset_pulse: assert property (bus_reset_event |=> !bus_reset_event)
        else $error("bus reset event longer than one cycle");
    a_event_pulse: assert property (general_bus_event |=> !general_bus_event)
        else $error("general event longer than one cycle");
    a_suspend_idle: assert property ($rose(suspended) |-> $past(dp_i && !dm_i))
        else $error("suspend entered on a non-idle bus");
    a_resume_nonj: assert property (suspended && pullup_on && !dp_oe && !(dp_i && !dm_i) |-> ##[1:4] !suspended)
        else $error("no resume on non-idle bus");
    a_oe_pair: assert property (dp_oe == dm_oe)
        else $error("line drivers enabled apart");
    c_bus_reset: cover property (bus_reset_event);
    c_suspend: cover property ($rose(suspended));
    c_resume: cover property ($fell(suspended));
    c_force: cover property ($rose(dp_oe));
endmodule
bind ubsc_bus_state_ctrl ubsc_checker u_chk (.pclk, .presetn, .vbus_valid,
    .phy_power_ok, .dp_i, .dm_i, .dp_oe, .dm_oe, .pullup_on, .pullup_strong,
    .phy_power_on, .traffic_allow, .suspended, .bus_reset_event,
    .general_bus_event, .phy_power_ready_event);
`default_nettype wire

// File: verification/ubsc_host_model.sv
/* Host side of the D+/D- lines: host driver, host pull-downs and the
   device pull-up, resolved into the levels the block samples.
   Assumes the bench commands the host driver. */
`timescale 1ns/1ps
`default_nettype none
module ubsc_host_model (
    input  wire logic       pullup_on,
    input  wire logic       dp_o,
    input  wire logic       dp_oe,
    input  wire logic       dm_o,
    input  wire logic       dm_oe,
    input  wire logic       host_drv,
    input  wire logic [1:0] host_ls,
    output logic            dp_i,
    output logic            dm_i
);
    // A driver wins; an undriven bus idles at J via the pull-up, else SE0.
    assign dp_i = dp_oe ? dp_o : host_drv ? host_ls[1] : pullup_on;
    assign dm_i = dm_oe ? dm_o : host_drv ? host_ls[0] : 1'b0;
endmodule
`default_nettype wire

// File: verification/tb_usb_device_bus_state_control.sv
/* Self-checking bench for the USB bus-state control block.
   Assumes the host model on the lines and APB access to the registers. */
`timescale 1ns/1ps
`default_nettype none
`include "ubsc_consts.vh"
module tb_usb_device_bus_state_control;
    logic pclk, psel = 0, penable = 0, pwrite = 0, presetn = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, vbus_valid = 1, phy_power_ok = 0, dp_i, dm_i;
    logic dp_o, dp_oe, dm_o, dm_oe, pullup_on, pullup_strong, phy_power_on;
    logic traffic_allow, suspended, bus_reset_event, general_bus_event;
    logic phy_power_ready_event, host_drv = 0;
    logic [1:0] host_ls = 0;
    int fails = 0, checks = 0;
    wire logic [3:0] wsig = {dp_oe, suspended, phy_power_ready_event, bus_reset_event};
    ubsc_bus_state_ctrl #(.SUSPEND_CYC(50)) u_dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .vbus_valid, .phy_power_ok, .dp_i, .dm_i, .dp_o, .dp_oe, .dm_o, .dm_oe,
        .pullup_on, .pullup_strong, .phy_power_on, .traffic_allow, .suspended,
        .bus_reset_event, .general_bus_event, .phy_power_ready_event);
    ubsc_host_model u_host (.pullup_on, .dp_o, .dp_oe, .dm_o, .dm_oe,
        .host_drv, .host_ls, .dp_i, .dm_i);
    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // --------------------
    // Shared tasks
    // --------------------
    task final_report;
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task timeout(input int n, input int lim);
        if (n >= lim)
        begin
            fails++;
            $display("MISMATCH at %0t: wait ran out", $time);
            final_report();
        end
    endtask
    // One APB transfer; waits for pready, then takes data and releases.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        timeout(n, 16);
    endtask
    // Waits, bounded, until the selected output takes the given level.
    task wait_for(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (wsig[s] !== v && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        timeout(n, lim);
    endtask
    // --------------------
    // Scenarios
    // --------------------
    task t_regs;
        apb(0, `UBSC_OFF_ENABLE, 0);
        chk(rd, 32'h0, "enable reset");
        apb(0, `UBSC_OFF_PULLUP, 0);
        chk(rd, 32'h0, "pullup reset");
        apb(0, `UBSC_OFF_EPEN, 0);
        chk(rd, 32'h1, "endpoint reset");
        apb(0, 12'h100, 0);
        chk(32'(er), 32'h1, "unmapped error");
        $display("test regs done");
    endtask
    task t_power;
        apb(1, `UBSC_OFF_ENABLE, 32'h1);
        repeat (3) @(posedge pclk);
        chk(32'(phy_power_on), 32'h1, "phy power");
        phy_power_ok <= 1'b1;
        wait_for(1, 1'b1, 300);
        apb(0, `UBSC_OFF_CAUSE, 0);
        chk(rd & 32'h1, 32'h1, "ready cause");
        apb(1, `UBSC_OFF_CAUSE, 32'hf);
        apb(1, `UBSC_OFF_PULLUP, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(pullup_on), 32'h1, "pull-up on");
        chk(32'(traffic_allow), 32'h0, "traffic before reset");
        vbus_valid <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(pullup_on), 32'h0, "pull-up without vbus");
        vbus_valid <= 1'b1;
        repeat (3) @(posedge pclk);
        $display("test power done");
    endtask
    task t_reset;
        apb(1, `UBSC_OFF_ADDR, 32'h55);
        apb(0, `UBSC_OFF_ADDR, 0);
        chk(rd, 32'h55, "address write");
        apb(1, `UBSC_OFF_EPEN, 32'hffff);
        host_ls <= 2'h0;
        host_drv <= 1'b1;
        wait_for(0, 1'b1, 400);
        chk(32'(pullup_strong), 32'h1, "strong pull-up");
        host_drv <= 1'b0;
        apb(0, `UBSC_OFF_ADDR, 0);
        chk(rd, 32'h0, "address cleared");
        apb(0, `UBSC_OFF_EPEN, 0);
        chk(rd, 32'h1, "endpoints off");
        chk(32'(traffic_allow), 32'h1, "traffic after reset");
        apb(0, `UBSC_OFF_CAUSE, 0);
        chk(rd & 32'h8, 32'h8, "reset cause");
        apb(1, `UBSC_OFF_CAUSE, 32'hf);
        $display("test reset done");
    endtask
    task t_suspend;
        wait_for(2, 1'b1, 200);
        chk(32'(general_bus_event), 32'h1, "suspend event");
        apb(0, `UBSC_OFF_CAUSE, 0);
        chk(rd & 32'h2, 32'h2, "suspend cause");
        apb(1, `UBSC_OFF_CAUSE, 32'hf);
        host_ls <= 2'h1;
        host_drv <= 1'b1;
        wait_for(2, 1'b0, 20);
        chk(32'(general_bus_event), 32'h1, "resume event");
        host_drv <= 1'b0;
        apb(0, `UBSC_OFF_CAUSE, 0);
        chk(rd & 32'h4, 32'h4, "resume cause");
        $display("test suspend done");
    endtask
    task t_decode;
        logic [15:0] tbl;
        tbl = 16'h8124;
        for (int i = 0; i < 4; i++)
        begin
            host_ls <= i[1:0];
            host_drv <= 1'b1;
            repeat (2) @(posedge pclk);
            apb(0, `UBSC_OFF_STATUS, 0);
            chk(rd & 32'hf, 32'(tbl[i*4 +: 4]), "line state");
        end
        host_drv <= 1'b0;
        $display("test decode done");
    endtask
    task t_force;
        apb(1, `UBSC_OFF_LINEVAL, 32'h1);
        apb(1, `UBSC_OFF_TASKS, 32'h1);
        wait_for(3, 1'b1, 10);
        chk(32'({dp_o, dm_o}), 32'h1, "forced K");
        apb(1, `UBSC_OFF_TASKS, 32'h2);
        wait_for(3, 1'b0, 10);
        apb(1, `UBSC_OFF_LINEVAL, 32'h0);
        apb(1, `UBSC_OFF_TASKS, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(dp_oe), 32'h0, "resume refused");
        apb(1, `UBSC_OFF_WAKEEN, 32'h1);
        apb(1, `UBSC_OFF_TASKS, 32'h1);
        wait_for(3, 1'b1, 10);
        chk(32'({dp_o, dm_o}), 32'h1, "resume K");
        apb(1, `UBSC_OFF_TASKS, 32'h2);
        wait_for(3, 1'b0, 10);
        $display("test force done");
    endtask
    task t_off;
        logic hit;
        hit = 0;
        apb(1, `UBSC_OFF_PULLUP, 0);
        repeat (2) @(posedge pclk);
        chk(32'(traffic_allow), 32'h0, "traffic when off");
        repeat (300)
        begin
            @(posedge pclk);
            hit = hit | bus_reset_event;
        end
        chk(32'(hit), 32'h0, "reset while off");
        apb(1, `UBSC_OFF_ENABLE, 0);
        apb(0, `UBSC_OFF_ENABLE, 0);
        chk(rd, 32'h1, "still enabled");
        repeat (150) @(posedge pclk);
        apb(0, `UBSC_OFF_ENABLE, 0);
        chk(rd, 32'h0, "disabled");
        chk(32'(phy_power_on), 32'h0, "phy off");
        $display("test off done");
    endtask
    // Main sequence: reset, scenarios, verdict.
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_power();
        t_reset();
        t_suspend();
        t_decode();
        t_force();
        t_off();
        final_report();
    end
endmodule
`default_nettype wire
